// ### lod_decoder.sv
// Logical-operation decoder: consumes instruction bytes and reports one decoded form.
// Assumes the fetch path presents one byte per cycle when byte_valid_i is high.
`timescale 1ns/100ps
`include "lod_map.svh"
module lod_decoder (
  input wire logic clk_i,                    // Core clock, 100 MHz
  input wire logic srst_i,                   // Synchronous reset, active high
  input wire logic byte_valid_i,             // Instruction byte present
  input wire logic [7:0] byte_i,             // Instruction byte
  output logic dec_valid_o,                  // One-cycle pulse: decode complete
  output lod_pkg::lod_op_t dec_op_o,         // Logical function
  output lod_pkg::lod_src_t dec_src_o,       // Operand sources
  output logic dec_word_o,                   // Word operands
  output logic dec_reg_is_dst_o,             // Register field is destination
  output logic dec_writes_o,                 // Result written back
  output logic dec_mem_o,                    // Memory operand
  output logic [1:0] dec_mod_o,              // Specifier mode field
  output logic [2:0] dec_reg_o,              // Specifier register field
  output logic [2:0] dec_rm_o,               // Specifier register/memory field
  output logic [15:0] dec_disp_o,            // Displacement, sign-extended
  output logic [15:0] dec_imm_o,             // Immediate data
  output logic [3:0] dec_clocks_o,           // Clock count of the instruction
  output logic unsup_o                       // One-cycle pulse: form not handled
);

  lod_pkg::lod_state_t st_r, st_nxt;
  lod_pkg::lod_op_t op_r, op_nxt;
  lod_pkg::lod_src_t src_r, src_nxt;
  logic w_r, w_nxt, d_r, d_nxt;
  logic [7:0] modrm_r, modrm_nxt;
  logic [1:0] dl_r, dl_nxt, il_r, il_nxt;
  logic [15:0] disp_r, disp_nxt, imm_r, imm_nxt;
  logic fin, bad;
  logic cls_hit, cls_word, cls_dir;
  lod_pkg::lod_op_t cls_op;
  lod_pkg::lod_src_t cls_src;
  logic dv_nxt, us_nxt, wr_nxt, mem_nxt;
  logic [3:0] clk_nxt;

  lod_opc_class u_class (
    .opc_i(byte_i),
    .hit_o(cls_hit),
    .op_o(cls_op),
    .src_o(cls_src),
    .word_o(cls_word),
    .dir_o(cls_dir)
  );

  function automatic logic [1:0] disp_len(input logic [7:0] m);
    logic [1:0] md;
    md = m[`LOD_MOD_HI:`LOD_MOD_LO];
    if (md == 2'h1) begin
      disp_len = 2'h1;
    end else if (md == 2'h2) begin
      disp_len = 2'h2;
    end else if (md == 2'h0 && m[`LOD_RM_HI:`LOD_RM_LO] == `LOD_RM_DIRECT) begin
      disp_len = 2'h2;
    end else begin
      disp_len = 2'h0;
    end
  endfunction : disp_len

  function automatic logic [3:0] clk_count(input lod_pkg::lod_op_t op,
                                           input lod_pkg::lod_src_t src, input logic mem);
    if (op != lod_pkg::LOD_OP_TEST) begin
      clk_count = mem ? `LOD_CLK_LOGIC_MEM : `LOD_CLK_LOGIC_REG;
    end else if (src == lod_pkg::LOD_SRC_IMM_ACC) begin
      clk_count = `LOD_CLK_TEST_IA;
    end else if (src == lod_pkg::LOD_SRC_IMM_RM) begin
      clk_count = mem ? `LOD_CLK_TEST_IR_MEM : `LOD_CLK_TEST_IR_REG;
    end else begin
      clk_count = mem ? `LOD_CLK_TEST_RR_MEM : `LOD_CLK_TEST_RR_REG;
    end
  endfunction : clk_count

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    src_nxt = src_r;
    w_nxt = w_r;
    d_nxt = d_r;
    modrm_nxt = modrm_r;
    dl_nxt = dl_r;
    il_nxt = il_r;
    disp_nxt = disp_r;
    imm_nxt = imm_r;
    fin = 1'b0;
    bad = 1'b0;
    if (byte_valid_i) begin
      unique case (st_r)
        lod_pkg::LOD_ST_OPC: begin
          if (!cls_hit) begin
            bad = 1'b1;
          end else begin
            op_nxt = cls_op;
            src_nxt = cls_src;
            w_nxt = cls_word;
            d_nxt = cls_dir;
            disp_nxt = `LOD_RST_WORD16;
            imm_nxt = `LOD_RST_WORD16;
            il_nxt = cls_word ? 2'h2 : 2'h1;
            dl_nxt = 2'h0;
            if (cls_src == lod_pkg::LOD_SRC_IMM_ACC) begin
              modrm_nxt = `LOD_RST_MODRM;
              st_nxt = lod_pkg::LOD_ST_IMM;
            end else begin
              st_nxt = lod_pkg::LOD_ST_MODRM;
            end
          end
        end
        lod_pkg::LOD_ST_MODRM: begin
          if (src_r == lod_pkg::LOD_SRC_IMM_RM &&
              byte_i[`LOD_REG_HI:`LOD_REG_LO] != `LOD_TEST_EXT) begin
            bad = 1'b1;
            st_nxt = lod_pkg::LOD_ST_OPC;
          end else begin
            modrm_nxt = byte_i;
            dl_nxt = disp_len(byte_i);
            if (src_r == lod_pkg::LOD_SRC_REG_RM) begin
              il_nxt = 2'h0;
            end
            if (disp_len(byte_i) != 2'h0) begin
              st_nxt = lod_pkg::LOD_ST_DISP;
            end else if (src_r == lod_pkg::LOD_SRC_IMM_RM) begin
              st_nxt = lod_pkg::LOD_ST_IMM;
            end else begin
              fin = 1'b1;
              st_nxt = lod_pkg::LOD_ST_OPC;
            end
          end
        end
        lod_pkg::LOD_ST_DISP: begin
          if (dl_r == 2'h1 && disp_len(modrm_r) == 2'h2) begin
            disp_nxt = {byte_i, disp_r[7:0]};
          end else begin
            disp_nxt = {{8{byte_i[7]}}, byte_i};
          end
          dl_nxt = dl_r - 2'h1;
          if (dl_r == 2'h1) begin
            if (il_r != 2'h0) begin
              st_nxt = lod_pkg::LOD_ST_IMM;
            end else begin
              fin = 1'b1;
              st_nxt = lod_pkg::LOD_ST_OPC;
            end
          end
        end
        lod_pkg::LOD_ST_IMM: begin
          if (il_r == 2'h1 && w_r) begin
            imm_nxt = {byte_i, imm_r[7:0]};
          end else begin
            imm_nxt = {8'h00, byte_i};
          end
          il_nxt = il_r - 2'h1;
          if (il_r == 2'h1) begin
            fin = 1'b1;
            st_nxt = lod_pkg::LOD_ST_OPC;
          end
        end
        default: begin
          st_nxt = lod_pkg::LOD_ST_OPC;
        end
      endcase
    end
    dv_nxt = fin;
    us_nxt = bad;
    mem_nxt = modrm_nxt[`LOD_MOD_HI:`LOD_MOD_LO] != `LOD_MOD_REG;
    wr_nxt = op_nxt != lod_pkg::LOD_OP_TEST;
    clk_nxt = clk_count(op_nxt, src_nxt, mem_nxt);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= lod_pkg::LOD_ST_OPC;
      op_r <= lod_pkg::LOD_OP_TEST;
      src_r <= lod_pkg::LOD_SRC_REG_RM;
      w_r <= 1'b0;
      d_r <= 1'b0;
      modrm_r <= `LOD_RST_MODRM;
      dl_r <= 2'h0;
      il_r <= 2'h0;
      disp_r <= `LOD_RST_WORD16;
      imm_r <= `LOD_RST_WORD16;
      dec_valid_o <= 1'b0;
      unsup_o <= 1'b0;
      dec_op_o <= lod_pkg::LOD_OP_TEST;
      dec_src_o <= lod_pkg::LOD_SRC_REG_RM;
      dec_word_o <= 1'b0;
      dec_reg_is_dst_o <= 1'b0;
      dec_writes_o <= 1'b0;
      dec_mem_o <= 1'b0;
      dec_mod_o <= 2'h0;
      dec_reg_o <= 3'h0;
      dec_rm_o <= 3'h0;
      dec_disp_o <= `LOD_RST_WORD16;
      dec_imm_o <= `LOD_RST_WORD16;
      dec_clocks_o <= 4'h0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      src_r <= src_nxt;
      w_r <= w_nxt;
      d_r <= d_nxt;
      modrm_r <= modrm_nxt;
      dl_r <= dl_nxt;
      il_r <= il_nxt;
      disp_r <= disp_nxt;
      imm_r <= imm_nxt;
      dec_valid_o <= dv_nxt;
      unsup_o <= us_nxt;
      if (fin) begin
        dec_op_o <= op_nxt;
        dec_src_o <= src_nxt;
        dec_word_o <= w_nxt;
        dec_reg_is_dst_o <= d_nxt;
        dec_writes_o <= wr_nxt;
        dec_mem_o <= mem_nxt;
        dec_mod_o <= modrm_nxt[`LOD_MOD_HI:`LOD_MOD_LO];
        dec_reg_o <= modrm_nxt[`LOD_REG_HI:`LOD_REG_LO];
        dec_rm_o <= modrm_nxt[`LOD_RM_HI:`LOD_RM_LO];
        dec_disp_o <= disp_nxt;
        dec_imm_o <= imm_nxt;
        dec_clocks_o <= clk_nxt;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_acc_word;
    st_r == lod_pkg::LOD_ST_OPC && byte_valid_i && byte_i[7:1] == 7'h54 && byte_i[0]
      ##1 byte_valid_i ##1 byte_valid_i;
  endsequence

  sequence s_xor_reg;
    st_r == lod_pkg::LOD_ST_OPC && byte_valid_i && byte_i[7:2] == 6'h0c
      ##1 byte_valid_i && byte_i[7:6] == 2'h3;
  endsequence

  sequence s_test_rr_reg;
    st_r == lod_pkg::LOD_ST_OPC && byte_valid_i && byte_i[7:1] == 7'h42
      ##1 byte_valid_i && byte_i[7:6] == 2'h3;
  endsequence

  test_rr_flags_a: assert property (s_test_rr_reg |=> dec_valid_o && !dec_writes_o &&
    dec_clocks_o == 4'h2)
    else $error("register flag test decoded wrongly");

  test_rr_mem_a: assert property (dec_valid_o && dec_op_o == lod_pkg::LOD_OP_TEST &&
    dec_src_o == lod_pkg::LOD_SRC_REG_RM && dec_mem_o |-> dec_clocks_o == 4'h6)
    else $error("memory flag test has wrong clock count");

  test_ext_bad_a: assert property (st_r == lod_pkg::LOD_ST_MODRM && byte_valid_i &&
    src_r == lod_pkg::LOD_SRC_IMM_RM && byte_i[5:3] != 3'h0 |=> unsup_o && !dec_valid_o)
    else $error("immediate test with nonzero middle field was accepted");

  test_imm_clk_a: assert property (dec_valid_o && dec_src_o == lod_pkg::LOD_SRC_IMM_RM
    |-> !dec_writes_o && dec_clocks_o == (dec_mem_o ? 4'h6 : 4'h3))
    else $error("immediate flag test has wrong result or clock count");

  acc_word_a: assert property (s_acc_word |=> dec_valid_o && !dec_writes_o &&
    dec_clocks_o == 4'h3 && dec_src_o == lod_pkg::LOD_SRC_IMM_ACC)
    else $error("accumulator word test did not finish after two data bytes");

  logic_clk_a: assert property (dec_valid_o && dec_op_o != lod_pkg::LOD_OP_TEST |->
    dec_writes_o && dec_clocks_o == (dec_mem_o ? 4'h7 : 4'h2))
    else $error("or or xor has wrong write-back or clock count");

  byte_imm_a: assert property (dec_valid_o && dec_src_o != lod_pkg::LOD_SRC_REG_RM &&
    !dec_word_o |-> dec_imm_o[15:8] == 8'h00)
    else $error("byte immediate has nonzero high byte");

  dir_bit_a: assert property (s_xor_reg |=> dec_valid_o &&
    dec_reg_is_dst_o == $past(byte_i[1], 2))
    else $error("direction bit not carried to the decode");

endmodule : lod_decoder

// ### lod_map.svh
// Constants of the logical-operation decoder: opcode patterns, field positions, counts.
// Assumes the including file is compiled after lod_pkg.sv.
// Overview of operation
// - 1000010w plus specifier: AND to flags only, 2 clocks register, 6 memory.
// - 1111011w, middle field 000, then immediate: AND to flags, 3 or 6 clocks.
// - 1010100w then immediate, no specifier: AND accumulator to flags, 3 clocks.
// - 000010dw OR, 001100dw XOR with specifier: 2 clocks register, 7 memory.
`ifndef LOD_MAP_SVH
`define LOD_MAP_SVH

`define LOD_PAT_TEST_RR 7'h42
`define LOD_PAT_TEST_IR 7'h7b
`define LOD_PAT_TEST_IA 7'h54
`define LOD_PAT_OR 6'h02
`define LOD_PAT_XOR 6'h0c
`define LOD_TEST_EXT 3'h0

`define LOD_BIT_W 0
`define LOD_BIT_D 1
`define LOD_MOD_HI 7
`define LOD_MOD_LO 6
`define LOD_REG_HI 5
`define LOD_REG_LO 3
`define LOD_RM_HI 2
`define LOD_RM_LO 0
`define LOD_MOD_REG 2'h3
`define LOD_RM_DIRECT 3'h6

`define LOD_CLK_TEST_RR_REG 4'h2
`define LOD_CLK_TEST_RR_MEM 4'h6
`define LOD_CLK_TEST_IR_REG 4'h3
`define LOD_CLK_TEST_IR_MEM 4'h6
`define LOD_CLK_TEST_IA 4'h3
`define LOD_CLK_LOGIC_REG 4'h2
`define LOD_CLK_LOGIC_MEM 4'h7

`define LOD_RST_MODRM 8'hc0
`define LOD_RST_WORD16 16'h0000

`endif

// ### lod_pkg.sv
// Types shared by the logical-operation decoder files.
// Assumes nothing of its surroundings.
package lod_pkg;

  typedef enum logic [1:0] {
    LOD_OP_TEST = 2'h0,
    LOD_OP_OR = 2'h1,
    LOD_OP_XOR = 2'h2
  } lod_op_t;

  typedef enum logic [1:0] {
    LOD_SRC_REG_RM = 2'h0,
    LOD_SRC_IMM_RM = 2'h1,
    LOD_SRC_IMM_ACC = 2'h2
  } lod_src_t;

  typedef enum logic [3:0] {
    LOD_ST_OPC = 4'h1,
    LOD_ST_MODRM = 4'h2,
    LOD_ST_DISP = 4'h4,
    LOD_ST_IMM = 4'h8
  } lod_state_t;

endpackage : lod_pkg

// ### lod_opc_class.sv
// Opcode classifier: tells which logical form a first instruction byte starts.
// Assumes a purely combinational use by the decoder that samples its outputs.
`timescale 1ns/100ps
`include "lod_map.svh"
module lod_opc_class (
  input wire logic [7:0] opc_i,       // First instruction byte
  output logic hit_o,                 // Byte opens a handled form
  output lod_pkg::lod_op_t op_o,      // Logical function
  output lod_pkg::lod_src_t src_o,    // Operand sources
  output logic word_o,                // Word operands
  output logic dir_o                  // Register field names the destination
);

  always_comb begin
    hit_o = 1'b1;
    op_o = lod_pkg::LOD_OP_TEST;
    src_o = lod_pkg::LOD_SRC_REG_RM;
    word_o = opc_i[`LOD_BIT_W];
    dir_o = 1'b0;
    if (opc_i[7:1] == `LOD_PAT_TEST_RR) begin
      src_o = lod_pkg::LOD_SRC_REG_RM;
    end else if (opc_i[7:1] == `LOD_PAT_TEST_IR) begin
      src_o = lod_pkg::LOD_SRC_IMM_RM;
    end else if (opc_i[7:1] == `LOD_PAT_TEST_IA) begin
      src_o = lod_pkg::LOD_SRC_IMM_ACC;
    end else if (opc_i[7:2] == `LOD_PAT_OR) begin
      op_o = lod_pkg::LOD_OP_OR;
      dir_o = opc_i[`LOD_BIT_D];
    end else if (opc_i[7:2] == `LOD_PAT_XOR) begin
      op_o = lod_pkg::LOD_OP_XOR;
      dir_o = opc_i[`LOD_BIT_D];
    end else begin
      hit_o = 1'b0;
    end
  end

endmodule : lod_opc_class

// ### lod_fetch_model.sv
// Fetch-path model: hands queued instruction bytes to the decoder, one per cycle.
// Assumes the bench pushes bytes through push and drives stall_i at the rising edge.
`timescale 1ns/100ps
module lod_fetch_model (
  input wire logic clk_i,     // Core clock
  input wire logic srst_i,    // Synchronous reset, active high
  input wire logic stall_i,   // Hold back the next byte this cycle
  output logic byte_valid_o,  // Instruction byte present
  output logic [7:0] byte_o   // Instruction byte
);
  logic [7:0] fifo_q[$];

  task automatic push(input logic [7:0] b);
    fifo_q.push_back(b);
  endtask : push

  function automatic int pending();
    return fifo_q.size();
  endfunction : pending

  // Between bytes the data lines flip so a stale byte can never pass as fresh.
  always @(posedge clk_i) begin
    if (srst_i) begin
      byte_valid_o <= 1'b0;
      byte_o <= 8'h00;
    end else if (!stall_i && fifo_q.size() > 0) begin
      byte_valid_o <= 1'b1;
      byte_o <= fifo_q.pop_front();
    end else begin
      byte_valid_o <= 1'b0;
      byte_o <= ~byte_o;
    end
  end
endmodule : lod_fetch_model

// ### test_lod_decoder.sv
// Self-checking bench for the logical-operation decoder with a queue-based reference.
// Assumes lod_pkg and the design files are compiled before this file.
`timescale 1ns/100ps
module test_lod_decoder;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic stall = 1'b0;
  logic byte_valid;
  logic [7:0] byte_val;
  logic dec_valid_o, dec_word_o, dec_reg_is_dst_o, dec_writes_o, dec_mem_o, unsup_o;
  lod_pkg::lod_op_t dec_op_o;
  lod_pkg::lod_src_t dec_src_o;
  logic [1:0] dec_mod_o;
  logic [2:0] dec_reg_o, dec_rm_o;
  logic [15:0] dec_disp_o, dec_imm_o;
  logic [3:0] dec_clocks_o;
  logic [52:0] exp_q[$];
  logic [52:0] got;
  logic [15:0] rng_state = 16'h004f;
  logic [15:0] stall_state = 16'h004f;
  int err_count = 0;
  int checks = 0;

  always #5 clk_i = ~clk_i;

  lod_fetch_model i_lod_fetch_model (.clk_i(clk_i), .srst_i(srst_i), .stall_i(stall),
    .byte_valid_o(byte_valid), .byte_o(byte_val));

  lod_decoder i_lod_decoder (.clk_i(clk_i), .srst_i(srst_i), .byte_valid_i(byte_valid),
    .byte_i(byte_val), .dec_valid_o(dec_valid_o), .dec_op_o(dec_op_o),
    .dec_src_o(dec_src_o), .dec_word_o(dec_word_o), .dec_reg_is_dst_o(dec_reg_is_dst_o),
    .dec_writes_o(dec_writes_o), .dec_mem_o(dec_mem_o), .dec_mod_o(dec_mod_o),
    .dec_reg_o(dec_reg_o), .dec_rm_o(dec_rm_o), .dec_disp_o(dec_disp_o),
    .dec_imm_o(dec_imm_o), .dec_clocks_o(dec_clocks_o), .unsup_o(unsup_o));

  assign got = {unsup_o, dec_op_o, dec_src_o, dec_word_o, dec_reg_is_dst_o, dec_writes_o,
    dec_mem_o, dec_mod_o, dec_reg_o, dec_rm_o, dec_disp_o, dec_imm_o, dec_clocks_o};

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [7:0] rnd8();
    rng_state = lfsr_next(rng_state);
    return rng_state[7:0];
  endfunction : rnd8

  always @(posedge clk_i) begin
    stall_state <= lfsr_next(stall_state);
    stall <= stall_state[3] & stall_state[6];
  end

  // Kinds: 0 flags AND reg, 1 flags AND imm, 2 flags AND acc, 3 OR, 4 XOR, 5 bad middle, 6 other.
  task automatic gen(input int kind);
    logic [7:0] opc, modrm;
    logic [7:0] bad_list[4];
    logic [15:0] dsp, imm, dsp_e, imm_e;
    logic [1:0] op_e, src_e, md;
    logic [3:0] clk_e;
    logic w, d, mem;
    int nd, ni;
    bad_list = '{8'h0c, 8'h34, 8'h80, 8'h90};
    modrm = rnd8();
    dsp = {rnd8(), rnd8()};
    imm = {rnd8(), rnd8()};
    w = rng_state[9];
    d = rng_state[10];
    case (kind)
      0: opc = {7'h42, w};
      1: begin
        opc = {7'h7b, w};
        modrm[5:3] = 3'h0;
      end
      2: opc = {7'h54, w};
      3: opc = {6'h02, d, w};
      4: opc = {6'h0c, d, w};
      5: begin
        opc = {7'h7b, w};
        if (modrm[5:3] == 3'h0) modrm[5:3] = 3'h5;
      end
      default: opc = bad_list[rng_state[12:11]];
    endcase
    if (kind == 2) modrm = 8'hc0;
    md = modrm[7:6];
    mem = (kind != 2) && (md != 2'h3);
    nd = (kind == 2) ? 0 : (md == 2'h1) ? 1 : (md == 2'h2) ? 2 :
      (md == 2'h0 && modrm[2:0] == 3'h6) ? 2 : 0;
    ni = (kind == 1 || kind == 2) ? (w ? 2 : 1) : 0;
    dsp_e = (nd == 2) ? dsp : (nd == 1) ? {{8{dsp[7]}}, dsp[7:0]} : 16'h0000;
    imm_e = (ni == 2) ? imm : (ni == 1) ? {8'h00, imm[7:0]} : 16'h0000;
    op_e = (kind == 3) ? lod_pkg::LOD_OP_OR : (kind == 4) ? lod_pkg::LOD_OP_XOR : 2'h0;
    src_e = (kind == 1) ? lod_pkg::LOD_SRC_IMM_RM : (kind == 2) ? lod_pkg::LOD_SRC_IMM_ACC : 2'h0;
    clk_e = (kind == 0) ? (mem ? 4'h6 : 4'h2) : (kind == 1) ? (mem ? 4'h6 : 4'h3) :
      (kind == 2) ? 4'h3 : (mem ? 4'h7 : 4'h2);
    i_lod_fetch_model.push(opc);
    if (kind != 2 && kind != 6) i_lod_fetch_model.push(modrm);
    if (kind < 5) begin
      for (int i = 0; i < nd; i++) i_lod_fetch_model.push(dsp[8*i +: 8]);
      for (int i = 0; i < ni; i++) i_lod_fetch_model.push(imm[8*i +: 8]);
      exp_q.push_back({1'b0, op_e, src_e, w, (kind >= 3) ? d : 1'b0, kind >= 3, mem, md,
        modrm[5:3], modrm[2:0], dsp_e, imm_e, clk_e});
    end else begin
      exp_q.push_back({1'b1, 52'h0});
    end
  endtask : gen

  task automatic final_report();
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  always @(posedge clk_i) begin
    if (!srst_i && (dec_valid_o === 1'b1 || unsup_o === 1'b1)) begin
      checks++;
      if (exp_q.size() == 0) begin
        err_count++;
        $display("unexpected at %0t: decode result with nothing pending", $time);
      end else if (exp_q[0][52] ? (unsup_o !== 1'b1 || dec_valid_o !== 1'b0) :
          (got !== exp_q[0])) begin
        err_count++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp_q[0]);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end

  initial begin
    #(20000 * 10);
    err_count++;
    $display("unexpected at %0t: run did not finish in time", $time);
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    checks++;
    if (got !== 53'h0 || dec_valid_o !== 1'b0) begin
      err_count++;
      $display("unexpected at %0t: outputs not cleared by reset", $time);
    end
    for (int k = 0; k < 7; k++) gen(k);
    repeat (250) gen(rnd8() % 7);
    for (int n = 0; n < 8000 && (exp_q.size() > 0 || i_lod_fetch_model.pending() > 0); n++) begin
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
    if (exp_q.size() > 0) begin
      err_count++;
      $display("unexpected at %0t: %0d decodes never reported", $time, exp_q.size());
    end
    final_report();
  end
endmodule : test_lod_decoder
